// [verilog/accc_ch1_regs.sv]
// channel 1 configuration and calibration registers behind AXI4-Lite
// assumes a single ref_clk domain; shared filter setting and samples
// come from logic on the same clock
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "accc_regs.svh"
module accc_ch1_regs #(
    parameter int ADDR_W = 12
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [3:0]        shared_dc_filter_setting,
    input  wire logic [23:0]       ch1_sample,
    input  wire logic              ch1_sample_valid,
    output logic [9:0]             ch1_phase_delay,
    output logic                   ch1_dc_filter_bypass,
    output logic [1:0]             ch1_input_select,
    output logic                   ch1_test_signal_on,
    output logic [3:0]             ch1_dc_filter_eff,
    output logic [23:0]            ch1_result,
    output logic                   ch1_result_valid
);

    localparam int WI_W = ADDR_W - 2;

    if (ADDR_W < 7 || ADDR_W > 32)
    begin : g_bad_addr
        $error("accc_ch1_regs: ADDR_W must hold the register indices");
    end

    function automatic logic is_hit(input logic [ADDR_W-1:0] a);
        logic [WI_W-1:0] w;
        w      = a[ADDR_W-1:2];
        is_hit = (w >= WI_W'(`ACCC_IDX_CFG)) && (w <= WI_W'(`ACCC_IDX_GAIN_LO));
    endfunction

    function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] a);
        logic [WI_W-1:0] d;
        d       = a[ADDR_W-1:2] - WI_W'(`ACCC_IDX_CFG);
        slot_of = d[2:0];
    endfunction

    function automatic logic [15:0] mask_of(input logic [2:0] s);
        case (s)
            3'h0:    mask_of = `ACCC_MASK_CFG;
            3'h1:    mask_of = `ACCC_MASK_FULL;
            3'h2:    mask_of = `ACCC_MASK_UPPER;
            3'h3:    mask_of = `ACCC_MASK_FULL;
            3'h4:    mask_of = `ACCC_MASK_UPPER;
            default: mask_of = 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] rst_of(input logic [2:0] s);
        case (s)
            3'h0:    rst_of = `ACCC_RST_CFG;
            3'h1:    rst_of = `ACCC_RST_OFS_HI;
            3'h2:    rst_of = `ACCC_RST_OFS_LO;
            3'h3:    rst_of = `ACCC_RST_GAIN_HI;
            3'h4:    rst_of = `ACCC_RST_GAIN_LO;
            default: rst_of = 16'h0000;
        endcase
    endfunction

    // register storage, slot 0 is the config register
    logic [15:0] regs_r [0:4];

    // write channel state
    logic        aw_have_r;
    logic        aw_hit_r;
    logic [2:0]  aw_slot_r;
    logic        w_have_r;
    logic [15:0] w_data_r;
    logic [1:0]  w_strb_r;
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;

    // read channel state
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    logic        test_on_r;
    logic [3:0]  filt_eff_r;

    wire logic        aw_take     = s_axi_awvalid & awready_r;
    wire logic        w_take      = s_axi_wvalid & wready_r;
    wire logic        wr_fire     = aw_have_r & w_have_r & ~bvalid_r;
    wire logic        aw_have_nxt = ~wr_fire & (aw_have_r | aw_take);
    wire logic        w_have_nxt  = ~wr_fire & (w_have_r | w_take);
    wire logic        bvalid_nxt  = wr_fire | (bvalid_r & ~s_axi_bready);
    wire logic        awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
    wire logic        wready_nxt  = ~w_have_nxt & ~bvalid_nxt;
    wire logic [15:0] lane_mask   = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire logic [15:0] wr_mask     = lane_mask & mask_of(aw_slot_r);
    wire logic [15:0] wr_old      = regs_r[aw_slot_r];
    wire logic [15:0] wr_merged   = (wr_old & ~wr_mask) | (w_data_r & wr_mask);

    wire logic        ar_take     = s_axi_arvalid & arready_r;
    wire logic        rd_hit      = is_hit(s_axi_araddr);
    wire logic [2:0]  rd_slot     = slot_of(s_axi_araddr);
    wire logic [15:0] rd_word     = regs_r[rd_slot] & mask_of(rd_slot);
    wire logic        rvalid_nxt  = ar_take | (rvalid_r & ~s_axi_rready);

    wire accc_pkg::accc_in_sel_t sel_now =
        accc_pkg::accc_in_sel_t'(regs_r[0][`ACCC_SEL_HI:`ACCC_SEL_LO]);
    wire logic test_on_nxt = (sel_now == accc_pkg::ACCC_SEL_POS_TEST) ||
                             (sel_now == accc_pkg::ACCC_SEL_NEG_TEST);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 5; i++)
            begin
                regs_r[i] <= rst_of(3'(i));
            end
        end
        else if (wr_fire && aw_hit_r)
        begin
            regs_r[aw_slot_r] <= wr_merged;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            aw_have_r <= 1'b0;
            aw_hit_r  <= 1'b0;
            aw_slot_r <= 3'h0;
            w_have_r  <= 1'b0;
            w_data_r  <= 16'h0000;
            w_strb_r  <= 2'h0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `ACCC_RESP_OKAY;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            if (aw_take)
            begin
                aw_hit_r  <= is_hit(s_axi_awaddr);
                aw_slot_r <= slot_of(s_axi_awaddr);
            end
            if (w_take)
            begin
                w_data_r <= s_axi_wdata[15:0];
                w_strb_r <= s_axi_wstrb[1:0];
            end
            if (wr_fire)
            begin
                bresp_r <= aw_hit_r ? `ACCC_RESP_OKAY : `ACCC_RESP_DECERR;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `ACCC_RESP_OKAY;
        end
        else
        begin
            arready_r <= ~rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_take)
            begin
                rdata_r <= rd_hit ? {16'h0000, rd_word} : 32'h00000000;
                rresp_r <= rd_hit ? `ACCC_RESP_OKAY : `ACCC_RESP_DECERR;
            end
        end
    end

    // per-channel view of the shared filter; zero means bypassed
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            test_on_r  <= 1'b0;
            filt_eff_r <= 4'h0;
        end
        else
        begin
            test_on_r  <= test_on_nxt;
            filt_eff_r <= regs_r[0][`ACCC_BYPASS_BIT] ?
                          4'h0 : shared_dc_filter_setting;
        end
    end

    accc_cal_if cal ();

    assign cal.sample       = ch1_sample;
    assign cal.sample_valid = ch1_sample_valid;
    assign cal.offset       = {regs_r[1], regs_r[2][15:8]};
    assign cal.gain         = {regs_r[3], regs_r[4][15:8]};

    accc_corrector u_corr (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .cal     (cal.corr)
    );

    assign s_axi_awready        = awready_r;
    assign s_axi_wready         = wready_r;
    assign s_axi_bvalid         = bvalid_r;
    assign s_axi_bresp          = bresp_r;
    assign s_axi_arready        = arready_r;
    assign s_axi_rvalid         = rvalid_r;
    assign s_axi_rdata          = rdata_r;
    assign s_axi_rresp          = rresp_r;
    assign ch1_phase_delay      =
        regs_r[0][`ACCC_PHASE_HI:`ACCC_PHASE_LO];
    assign ch1_dc_filter_bypass = regs_r[0][`ACCC_BYPASS_BIT];
    assign ch1_input_select     = regs_r[0][`ACCC_SEL_HI:`ACCC_SEL_LO];
    assign ch1_test_signal_on   = test_on_r;
    assign ch1_dc_filter_eff    = filt_eff_r;
    assign ch1_result           = cal.result;
    assign ch1_result_valid     = cal.result_valid;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_commit(logic [2:0] sl);
        wr_fire && aw_hit_r && aw_slot_r == sl;
    endsequence

    sequence s_both_taken;
        aw_take && w_take;
    endsequence

    phase_reset_a: assert property (
        $past(sys_rst) |-> ch1_phase_delay == 10'h000 &&
            !ch1_dc_filter_bypass && ch1_input_select == 2'h0)
        else $error("config not zero after reset");

    gain_reset_a: assert property (
        $past(sys_rst) |-> cal.gain == 24'h800000 && cal.offset == 24'h000000)
        else $error("calibration reset values wrong");

    cfg_rsvd_a: assert property (
        regs_r[0][5:3] == 3'h0 &&
            (!s_axi_rvalid || s_axi_rdata[31:16] == 16'h0000))
        else $error("reserved bits not zero");

    bypass_filter_a: assert property (
        !$past(sys_rst) |-> ch1_dc_filter_eff == ($past(ch1_dc_filter_bypass) ?
            4'h0 : $past(shared_dc_filter_setting)))
        else $error("effective filter setting wrong");

    sel_write_a: assert property (
        s_commit(3'h0) and w_strb_r[0] |=>
            ch1_input_select == $past(w_data_r[1:0]) ##1
            ch1_test_signal_on == ch1_input_select[1])
        else $error("input select write not applied");

    ofs_high_a: assert property (
        s_commit(3'h1) and w_strb_r == 2'h3 |=>
            cal.offset[23:8] == $past(w_data_r))
        else $error("offset high write not applied");

    ofs_low_a: assert property (
        s_commit(3'h2) and w_strb_r[1] |=>
            cal.offset[7:0] == $past(w_data_r[15:8]) && regs_r[2][7:0] == 8'h00)
        else $error("offset low write wrong");

    gain_low_a: assert property (
        s_commit(3'h4) and w_strb_r[1] |=>
            cal.gain[7:0] == $past(w_data_r[15:8]) && $stable(cal.gain[23:8]))
        else $error("gain low write wrong");

    wr_resp_a: assert property (
        s_both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid && !s_axi_awready)
        else $error("write response not two cycles after take");

    rd_unmapped_a: assert property (
        ar_take && !rd_hit |=> s_axi_rvalid &&
            s_axi_rresp == `ACCC_RESP_DECERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read answer wrong");

endmodule

// [verilog/accc_regs.svh]
// register offsets, field positions and reset values of the channel 1
// calibration bank; included by every design file that decodes it
// Functional notes
// - Config 15:6 is a signed phase delay in modulator clocks, reset zero.
// - Config bits 5:3 are read-only and always read zero.
// - Config bit 2 set bypasses the dc filter here, clear follows shared.
// - Config bits 1:0 pick pins, shorted, positive test or negative test.
// - Offset high holds offset bits 23:8 in all sixteen bits, reset zero.
// - Offset low holds offset bits 7:0 in its upper byte, reset zero.
// - Gain high holds gain bits 23:8, gain low bits 7:0 in its upper byte.
// - The 24-bit gain is unsigned, zero to just below two in 2^-23 steps.
// - Gain high resets to 8000 hex for unity gain, all else resets to zero.
// - A shared four-bit dc filter setting applies while bypass is clear.
`ifndef ACCC_REGS_SVH
`define ACCC_REGS_SVH

// word indices; byte address is four times the index
`define ACCC_IDX_CFG      8'h0E
`define ACCC_IDX_OFS_HI   8'h0F
`define ACCC_IDX_OFS_LO   8'h10
`define ACCC_IDX_GAIN_HI  8'h11
`define ACCC_IDX_GAIN_LO  8'h12

`define ACCC_RST_CFG      16'h0000
`define ACCC_RST_OFS_HI   16'h0000
`define ACCC_RST_OFS_LO   16'h0000
`define ACCC_RST_GAIN_HI  16'h8000
`define ACCC_RST_GAIN_LO  16'h0000

// writable bits of each register
`define ACCC_MASK_CFG     16'hFFC7
`define ACCC_MASK_FULL    16'hFFFF
`define ACCC_MASK_UPPER   16'hFF00

`define ACCC_PHASE_HI     15
`define ACCC_PHASE_LO     6
`define ACCC_BYPASS_BIT   2
`define ACCC_SEL_HI       1
`define ACCC_SEL_LO       0

`define ACCC_DATA_W       24
`define ACCC_GAIN_FRAC    23

`define ACCC_RESP_OKAY    2'h0
`define ACCC_RESP_DECERR  2'h3

`endif

// [verilog/accc_pkg.sv]
// types shared by the channel 1 calibration bank
// assumes nothing beyond the register header
package accc_pkg;

    typedef enum logic [1:0] {
        ACCC_SEL_PINS,
        ACCC_SEL_SHORTED,
        ACCC_SEL_POS_TEST,
        ACCC_SEL_NEG_TEST
    } accc_in_sel_t;

    typedef logic [23:0] accc_word_t;

endpackage

// [verilog/accc_cal_if.sv]
// carrier between the register bank and the sample corrector
// assumes both ends run on the same clock
interface accc_cal_if;
    accc_pkg::accc_word_t sample;
    logic                 sample_valid;
    accc_pkg::accc_word_t offset;
    accc_pkg::accc_word_t gain;
    accc_pkg::accc_word_t result;
    logic                 result_valid;

    modport corr
    (
        input  sample,
        input  sample_valid,
        input  offset,
        input  gain,
        output result,
        output result_valid
    );

    modport bank
    (
        output sample,
        output sample_valid,
        output offset,
        output gain,
        input  result,
        input  result_valid
    );
endinterface

// [verilog/accc_corrector.sv]
// applies offset and gain correction to channel 1 samples
// assumes samples arrive from logic on ref_clk, one per valid cycle
`include "accc_regs.svh"
module accc_corrector #(
    parameter int FRAC_W = `ACCC_GAIN_FRAC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    accc_cal_if.corr cal
);

    if (FRAC_W < 1 || FRAC_W > 48)
    begin : g_bad_frac
        $error("accc_corrector: FRAC_W out of range");
    end

    // subtract offset, scale by unsigned gain, saturate to 24 bits
    function automatic logic [23:0] correct(
        input logic [23:0] s,
        input logic [23:0] o,
        input logic [23:0] g
    );
        logic signed [24:0] diff;
        logic signed [49:0] prod;
        logic signed [49:0] scaled;
        diff   = $signed({s[23], s}) - $signed({o[23], o});
        prod   = diff * $signed({1'b0, g});
        scaled = prod >>> FRAC_W;
        if (scaled[49:23] == {27{1'b0}} || scaled[49:23] == {27{1'b1}})
        begin
            correct = scaled[23:0];
        end
        else if (scaled[49])
        begin
            correct = 24'h800000;
        end
        else
        begin
            correct = 24'h7FFFFF;
        end
    endfunction

    logic [23:0] result_r;
    logic        result_valid_r;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            result_r       <= 24'h000000;
            result_valid_r <= 1'b0;
        end
        else
        begin
            result_valid_r <= cal.sample_valid;
            if (cal.sample_valid)
            begin
                result_r <= correct(cal.sample, cal.offset, cal.gain);
            end
        end
    end

    assign cal.result       = result_r;
    assign cal.result_valid = result_valid_r;

    corr_value_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cal.sample_valid |=> cal.result_valid && cal.result ==
            correct($past(cal.sample), $past(cal.offset), $past(cal.gain)))
        else $error("corrected sample mismatch");

    corr_hold_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !cal.sample_valid |=> !cal.result_valid && $stable(cal.result))
        else $error("result changed without a sample");

endmodule

// [verif/adc_channel1_config_calibration_test.sv]
// self-checking bench for the channel 1 calibration register bank
// assumes the bank alone on ref_clk, reached over AXI4-Lite
`include "accc_regs.svh"
module adc_channel1_config_calibration_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] ADR [5] = '{{2'h0, `ACCC_IDX_CFG, 2'h0},
        {2'h0, `ACCC_IDX_OFS_HI, 2'h0}, {2'h0, `ACCC_IDX_OFS_LO, 2'h0},
        {2'h0, `ACCC_IDX_GAIN_HI, 2'h0}, {2'h0, `ACCC_IDX_GAIN_LO, 2'h0}};
    localparam logic [15:0] RST [5] = '{`ACCC_RST_CFG, `ACCC_RST_OFS_HI,
        `ACCC_RST_OFS_LO, `ACCC_RST_GAIN_HI, `ACCC_RST_GAIN_LO};
    localparam logic [15:0] MSK [5] = '{`ACCC_MASK_CFG, `ACCC_MASK_FULL,
        `ACCC_MASK_UPPER, `ACCC_MASK_FULL, `ACCC_MASK_UPPER};

    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b1;
    logic [11:0] s_axi_araddr = 12'h000;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b1;
    logic [3:0]  shared_dc_filter_setting = 4'h0;
    logic [23:0] ch1_sample = 24'h000000;
    logic        ch1_sample_valid = 1'b0;
    logic [9:0]  ch1_phase_delay;
    logic        ch1_dc_filter_bypass;
    logic [1:0]  ch1_input_select;
    logic        ch1_test_signal_on;
    logic [3:0]  ch1_dc_filter_eff;
    logic [23:0] ch1_result;
    logic        ch1_result_valid;

    logic [33:0] rq [$];
    logic [1:0]  bq [$];
    logic [23:0] sq [$];
    logic [15:0] mir [5];
    logic [23:0] ofs;
    logic [23:0] gn;
    logic [31:0] seed = 32'h0131B8AA;
    int          errors = 0;
    int          n_tests = 0;

    accc_ch1_regs dut_u (.*);

    always #10 ref_clk = ~ref_clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected corrected sample, saturated to 24 bits
    function automatic logic [23:0] corr(logic [23:0] s, logic [23:0] o,
                                         logic [23:0] g);
        logic signed [24:0] d;
        logic signed [49:0] q;
        d = $signed({s[23], s}) - $signed({o[23], o});
        q = (d * $signed({1'b0, g})) >>> 23;
        if (q > $signed(50'h7FFFFF))
            return 24'h7FFFFF;
        if (q < -$signed(50'h800000))
            return 24'h800000;
        return q[23:0];
    endfunction

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d,
                      input logic [3:0] st, input logic [1:0] rs);
        @(posedge ref_clk);
        bq.push_back(rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'hDEAD, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
                break;
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [15:0] d,
                      input logic [1:0] rs);
        @(posedge ref_clk);
        rq.push_back({rs, 16'h0000, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
                break;
        end
    endtask

    task automatic rdall();
        for (int k = 0; k < 5; k++)
            rd(ADR[k], mir[k], `ACCC_RESP_OKAY);
    endtask

    // consecutive calls keep the valid high: back-to-back samples
    task automatic smp(input logic [23:0] s);
        @(posedge ref_clk);
        sq.push_back(corr(s, ofs, gn));
        ch1_sample <= s;
        ch1_sample_valid <= 1'b1;
    endtask

    task automatic smp_run(input int n);
        logic [31:0] t;
        smp(24'h7FFFFF);
        smp(24'h800000);
        for (int i = 0; i < n; i++)
        begin
            t = rnd();
            smp(t[23:0]);
        end
        @(posedge ref_clk);
        ch1_sample_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    always @(posedge ref_clk)
    begin
        if (s_axi_rvalid === 1'b1)
            chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid === 1'b1)
            chk(s_axi_bresp, bq.pop_front());
        if (ch1_result_valid === 1'b1)
            chk(ch1_result, sq.pop_front());
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end

    initial
    begin
        logic [31:0] t;
        logic [31:0] u;
        logic [15:0] cfg;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        mir = RST;
        rdall();
        ofs = 24'h000000;
        gn = 24'h800000;
        smp_run(6);
        for (int k = 0; k < 5; k++)
        begin
            wr(ADR[k], 16'hFFFF, 4'hF, `ACCC_RESP_OKAY);
            mir[k] = MSK[k];
        end
        rdall();
        wr(ADR[1], 16'h1234, 4'h1, `ACCC_RESP_OKAY);
        wr(ADR[3], 16'h5678, 4'h2, `ACCC_RESP_OKAY);
        mir[1] = 16'hFF34;
        mir[3] = 16'h56FF;
        wr(12'h04C, 16'h0000, 4'hF, `ACCC_RESP_DECERR);
        wr(12'h034, 16'h0000, 4'hF, `ACCC_RESP_DECERR);
        rd(12'h04C, 16'h0000, `ACCC_RESP_DECERR);
        rdall();
        for (int k = 0; k < 8; k++)
        begin
            t = rnd();
            cfg = {t[15:6], 3'b101, k[2], k[1:0]};
            @(posedge ref_clk);
            shared_dc_filter_setting <= t[3:0];
            wr(ADR[0], cfg, 4'h3, `ACCC_RESP_OKAY);
            rd(ADR[0], cfg & 16'hFFC7, `ACCC_RESP_OKAY);
            repeat (2) @(posedge ref_clk);
            chk(ch1_phase_delay, t[15:6]);
            chk(ch1_dc_filter_bypass, k[2]);
            chk(ch1_input_select, k[1:0]);
            chk(ch1_test_signal_on, k[1]);
            chk(ch1_dc_filter_eff, k[2] ? 4'h0 : t[3:0]);
        end
        for (int r = 0; r < 5; r++)
        begin
            t = rnd();
            u = rnd();
            if (r >= 3)
            begin
                u = 32'h00FFFFFF;
                t = (r == 3) ? 32'h007FFFFF : 32'h00800000;
            end
            wr(ADR[1], t[23:8], 4'h3, `ACCC_RESP_OKAY);
            wr(ADR[2], {t[7:0], u[31:24]}, 4'h3, `ACCC_RESP_OKAY);
            wr(ADR[3], u[23:8], 4'h3, `ACCC_RESP_OKAY);
            wr(ADR[4], {u[7:0], t[31:24]}, 4'h3, `ACCC_RESP_OKAY);
            ofs = t[23:0];
            gn = u[23:0];
            smp_run(6);
        end
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({ch1_phase_delay, ch1_dc_filter_bypass, ch1_input_select},
            13'h0000);
        mir = RST;
        rdall();
        ofs = 24'h000000;
        gn = 24'h800000;
        smp_run(3);
        give_verdict();
    end
endmodule
